// *** verilog/iorsd_pkg.sv ***
// package: i/o register map, masks, request and answer carriers for the decoder
package iorsd_pkg;

    // ==================== address ranges
    localparam logic [7:0] IO_PORT_TOP  = 8'h3f;
    localparam logic [7:0] BIT_OP_TOP   = 8'h1f;
    localparam logic [7:0] DATA_IO_BASE = 8'h20;
    localparam logic [7:0] EXT_IO_BASE  = 8'h60;
    localparam int         IO_COUNT     = 64;
    localparam int         IO_AW        = 6;
    localparam int         DATA_W       = 8;
    localparam int         NUM_PORTS    = 4;
    localparam logic [7:0] IO_RESET_VAL = 8'h00;
    localparam logic [7:0] FULL_MASK    = 8'hff;
    localparam logic [7:0] BIT0_ONE     = 8'h01;

    // ==================== port addresses
    localparam logic [5:0] OFS_PORT_A_INPUT_PINS     = 6'h00;
    localparam logic [5:0] OFS_PORT_A_DIRECTION      = 6'h01;
    localparam logic [5:0] OFS_PORT_A_OUTPUT         = 6'h02;
    localparam logic [5:0] OFS_PORT_B_INPUT_PINS     = 6'h03;
    localparam logic [5:0] OFS_PORT_B_DIRECTION      = 6'h04;
    localparam logic [5:0] OFS_PORT_B_OUTPUT         = 6'h05;
    localparam logic [5:0] OFS_PORT_C_INPUT_PINS     = 6'h06;
    localparam logic [5:0] OFS_PORT_C_DIRECTION      = 6'h07;
    localparam logic [5:0] OFS_PORT_C_OUTPUT         = 6'h08;
    localparam logic [5:0] OFS_PORT_D_INPUT_PINS     = 6'h09;
    localparam logic [5:0] OFS_PORT_D_DIRECTION      = 6'h0a;
    localparam logic [5:0] OFS_PORT_D_OUTPUT         = 6'h0b;
    localparam logic [5:0] OFS_TIMER0_FLAGS          = 6'h15;
    localparam logic [5:0] OFS_TIMER1_FLAGS          = 6'h16;
    localparam logic [5:0] OFS_TIMER2_FLAGS          = 6'h17;
    localparam logic [5:0] OFS_PIN_CHANGE_FLAGS      = 6'h1b;
    localparam logic [5:0] OFS_EXTERNAL_IRQ_FLAGS    = 6'h1c;
    localparam logic [5:0] OFS_EXTERNAL_IRQ_MASK     = 6'h1d;
    localparam logic [5:0] OFS_GENERAL_PURPOSE_0     = 6'h1e;
    localparam logic [5:0] OFS_EEPROM_CONTROL        = 6'h1f;
    localparam logic [5:0] OFS_EEPROM_DATA           = 6'h20;
    localparam logic [5:0] OFS_EEPROM_ADDRESS_LOW    = 6'h21;
    localparam logic [5:0] OFS_EEPROM_ADDRESS_HIGH   = 6'h22;
    localparam logic [5:0] OFS_TIMER_GENERAL_CONTROL = 6'h23;
    localparam logic [5:0] OFS_TIMER0_CONTROL_A      = 6'h24;
    localparam logic [5:0] OFS_TIMER0_CONTROL_B      = 6'h25;
    localparam logic [5:0] OFS_TIMER0_COUNT          = 6'h26;
    localparam logic [5:0] OFS_TIMER0_COMPARE_A      = 6'h27;
    localparam logic [5:0] OFS_TIMER0_COMPARE_B      = 6'h28;
    localparam logic [5:0] OFS_GENERAL_PURPOSE_1     = 6'h2a;
    localparam logic [5:0] OFS_GENERAL_PURPOSE_2     = 6'h2b;
    localparam logic [5:0] OFS_SERIAL_PERIPH_CONTROL = 6'h2c;
    localparam logic [5:0] OFS_SERIAL_PERIPH_STATUS  = 6'h2d;
    localparam logic [5:0] OFS_SERIAL_PERIPH_DATA    = 6'h2e;
    localparam logic [5:0] OFS_COMPARATOR_CTRL_STAT  = 6'h30;
    localparam logic [5:0] OFS_DEBUG_DATA            = 6'h31;
    localparam logic [5:0] OFS_SLEEP_CONTROL         = 6'h33;
    localparam logic [5:0] OFS_RESET_CAUSE_STATUS    = 6'h34;
    localparam logic [5:0] OFS_CORE_CONTROL          = 6'h35;
    localparam logic [5:0] OFS_SELF_PROGRAM_CONTROL  = 6'h37;

    // ==================== implemented bits of narrow registers
    localparam logic [7:0] MSK_TIMER0_FLAGS          = 8'h07;
    localparam logic [7:0] MSK_TIMER1_FLAGS          = 8'h27;
    localparam logic [7:0] MSK_TIMER2_FLAGS          = 8'h07;
    localparam logic [7:0] MSK_PIN_CHANGE_FLAGS      = 8'h0f;
    localparam logic [7:0] MSK_EXTERNAL_IRQ_FLAGS    = 8'h07;
    localparam logic [7:0] MSK_EXTERNAL_IRQ_MASK     = 8'h07;
    localparam logic [7:0] MSK_EEPROM_CONTROL        = 8'h3f;
    localparam logic [7:0] MSK_EEPROM_ADDRESS_HIGH   = 8'h0f;
    localparam logic [7:0] MSK_TIMER_GENERAL_CONTROL = 8'h83;
    localparam logic [7:0] MSK_TIMER0_CONTROL_A      = 8'hf3;
    localparam logic [7:0] MSK_TIMER0_CONTROL_B      = 8'hcf;
    localparam logic [7:0] MSK_SERIAL_PERIPH_STATUS  = 8'hc1;
    localparam logic [7:0] MSK_SLEEP_CONTROL         = 8'h0f;
    localparam logic [7:0] MSK_RESET_CAUSE_STATUS    = 8'h1f;
    localparam logic [7:0] MSK_CORE_CONTROL          = 8'h93;

    // ==================== types
    typedef enum logic [3:0] {
        kind_rsvd = 4'b0001,
        kind_rw   = 4'b0010,
        kind_pin  = 4'b0100,
        kind_w1c  = 4'b1000
    } iorsd_kind_e;

    typedef enum logic [3:0] {
        in_op               = 4'h0,
        out_op              = 4'h1,
        set_io_bit_op       = 4'h2,
        clear_io_bit_op     = 4'h3,
        skip_if_io_bit_one  = 4'h4,
        skip_if_io_bit_zero = 4'h5,
        load_indirect_op    = 4'h6,
        load_direct_op      = 4'h7,
        load_displaced_op   = 4'h8,
        store_indirect_op   = 4'h9,
        store_direct_op     = 4'ha,
        store_displaced_op  = 4'hb
    } iorsd_op_e;

    typedef struct packed {
        iorsd_op_e   op;
        logic [7:0]  addr;
        logic [2:0]  bit_sel;
        logic [7:0]  wdata;
    } iorsd_req_s;

    typedef struct packed {
        logic        valid;
        logic        refused;
        logic        skip;
        logic [7:0]  rdata;
    } iorsd_rsp_s;

    typedef struct packed {
        logic [7:0]  timer0;
        logic [7:0]  timer1;
        logic [7:0]  timer2;
        logic [7:0]  pin_change;
        logic [7:0]  ext_irq;
    } iorsd_flag_s;

endpackage

// *** verilog/iorsd_top.sv ***
// module: low i/o register space decoder with bit access and write-one-to-clear flags
//
// Contract
// - bit set and bit clear act only on port addresses 0x00 to 0x1f and are refused above.
// - skip-if-one and skip-if-zero test one chosen bit of a register in 0x00 to 0x1f.
// - flag bits clear when a one is written to them and keep their value on a zero.
// - bit set and clear rewrite the whole register: bit set clears every flag read as set, bit clear clears all of them but the chosen bit.
// - port in and out decode the 64 port addresses 0x00 to 0x3f.
// - data-space load and store find an i/o register at its port address plus 0x20.
// - the extended range 0x60 to 0xff is reached by load and store only, never by port ops.
`timescale 1ns/1ps
`default_nettype none

module iorsd_top
    import iorsd_pkg::*;
#(
    parameter int IO_W = iorsd_pkg::DATA_W
) (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     nrst,
    // request from the core
    input  wire logic                     req_valid,
    input  wire iorsd_pkg::iorsd_req_s    req,
    // answer to the core
    output iorsd_pkg::iorsd_rsp_s         rsp,
    // peripheral side
    input  wire logic [iorsd_pkg::NUM_PORTS-1:0][iorsd_pkg::DATA_W-1:0] port_pins,
    input  wire iorsd_pkg::iorsd_flag_s   flag_set,
    output logic [iorsd_pkg::IO_COUNT-1:0][iorsd_pkg::DATA_W-1:0]       io_image
);
    import iorsd_pkg::*;

    // ====================
    // elaboration check
    if (IO_W != DATA_W) begin : g_bad_width
        $error("iorsd_top: only an 8-bit register width is supported");
    end

    // ====================
    // lookup tables
    function automatic iorsd_kind_e kind_of(input logic [5:0] idx);
        case (idx)
            OFS_PORT_A_INPUT_PINS, OFS_PORT_B_INPUT_PINS,
            OFS_PORT_C_INPUT_PINS, OFS_PORT_D_INPUT_PINS: kind_of = kind_pin;
            OFS_TIMER0_FLAGS, OFS_TIMER1_FLAGS, OFS_TIMER2_FLAGS,
            OFS_PIN_CHANGE_FLAGS, OFS_EXTERNAL_IRQ_FLAGS: kind_of = kind_w1c;
            OFS_PORT_A_DIRECTION, OFS_PORT_A_OUTPUT,
            OFS_PORT_B_DIRECTION, OFS_PORT_B_OUTPUT,
            OFS_PORT_C_DIRECTION, OFS_PORT_C_OUTPUT,
            OFS_PORT_D_DIRECTION, OFS_PORT_D_OUTPUT,
            OFS_EXTERNAL_IRQ_MASK, OFS_GENERAL_PURPOSE_0,
            OFS_EEPROM_CONTROL, OFS_EEPROM_DATA,
            OFS_EEPROM_ADDRESS_LOW, OFS_EEPROM_ADDRESS_HIGH,
            OFS_TIMER_GENERAL_CONTROL, OFS_TIMER0_CONTROL_A,
            OFS_TIMER0_CONTROL_B, OFS_TIMER0_COUNT,
            OFS_TIMER0_COMPARE_A, OFS_TIMER0_COMPARE_B,
            OFS_GENERAL_PURPOSE_1, OFS_GENERAL_PURPOSE_2,
            OFS_SERIAL_PERIPH_CONTROL, OFS_SERIAL_PERIPH_STATUS,
            OFS_SERIAL_PERIPH_DATA, OFS_COMPARATOR_CTRL_STAT,
            OFS_DEBUG_DATA, OFS_SLEEP_CONTROL,
            OFS_RESET_CAUSE_STATUS, OFS_CORE_CONTROL,
            OFS_SELF_PROGRAM_CONTROL: kind_of = kind_rw;
            default: kind_of = kind_rsvd;
        endcase
    endfunction

    function automatic logic [7:0] mask_of(input logic [5:0] idx);
        case (idx)
            OFS_TIMER0_FLAGS:          mask_of = MSK_TIMER0_FLAGS;
            OFS_TIMER1_FLAGS:          mask_of = MSK_TIMER1_FLAGS;
            OFS_TIMER2_FLAGS:          mask_of = MSK_TIMER2_FLAGS;
            OFS_PIN_CHANGE_FLAGS:      mask_of = MSK_PIN_CHANGE_FLAGS;
            OFS_EXTERNAL_IRQ_FLAGS:    mask_of = MSK_EXTERNAL_IRQ_FLAGS;
            OFS_EXTERNAL_IRQ_MASK:     mask_of = MSK_EXTERNAL_IRQ_MASK;
            OFS_EEPROM_CONTROL:        mask_of = MSK_EEPROM_CONTROL;
            OFS_EEPROM_ADDRESS_HIGH:   mask_of = MSK_EEPROM_ADDRESS_HIGH;
            OFS_TIMER_GENERAL_CONTROL: mask_of = MSK_TIMER_GENERAL_CONTROL;
            OFS_TIMER0_CONTROL_A:      mask_of = MSK_TIMER0_CONTROL_A;
            OFS_TIMER0_CONTROL_B:      mask_of = MSK_TIMER0_CONTROL_B;
            OFS_SERIAL_PERIPH_STATUS:  mask_of = MSK_SERIAL_PERIPH_STATUS;
            OFS_SLEEP_CONTROL:         mask_of = MSK_SLEEP_CONTROL;
            OFS_RESET_CAUSE_STATUS:    mask_of = MSK_RESET_CAUSE_STATUS;
            OFS_CORE_CONTROL:          mask_of = MSK_CORE_CONTROL;
            default:                   mask_of = FULL_MASK;
        endcase
    endfunction

    function automatic logic [7:0] flag_of(input logic [5:0] idx,
                                           input iorsd_flag_s f);
        case (idx)
            OFS_TIMER0_FLAGS:       flag_of = f.timer0;
            OFS_TIMER1_FLAGS:       flag_of = f.timer1;
            OFS_TIMER2_FLAGS:       flag_of = f.timer2;
            OFS_PIN_CHANGE_FLAGS:   flag_of = f.pin_change;
            OFS_EXTERNAL_IRQ_FLAGS: flag_of = f.ext_irq;
            default:                flag_of = IO_RESET_VAL;
        endcase
    endfunction

    function automatic logic [1:0] pin_sel(input logic [5:0] idx);
        case (idx)
            OFS_PORT_B_INPUT_PINS: pin_sel = 2'h1;
            OFS_PORT_C_INPUT_PINS: pin_sel = 2'h2;
            OFS_PORT_D_INPUT_PINS: pin_sel = 2'h3;
            default:               pin_sel = 2'h0;
        endcase
    endfunction

    // ====================
    // storage and decode signals
    logic [IO_COUNT-1:0][DATA_W-1:0] mem_q;
    iorsd_rsp_s                      rsp_q;
    logic [5:0]                      idx;
    logic [7:0]                      data_off;
    logic                            in_range;
    logic                            refused;
    logic                            is_wr;
    logic                            is_bit;
    logic                            is_skip;
    logic                            want_one;
    logic [7:0]                      cur;
    logic [7:0]                      bit_m;
    logic [7:0]                      wval;
    logic                            wr_go;

    // ====================
    // request decode
    always_comb begin
        data_off = req.addr - DATA_IO_BASE;
        idx      = req.addr[5:0];
        in_range = 1'b0;
        refused  = 1'b0;
        is_wr    = 1'b0;
        is_bit   = 1'b0;
        is_skip  = 1'b0;
        want_one = 1'b0;
        case (req.op)
            in_op, out_op: begin
                // port ops carry a 6-bit address; anything above cannot be extended space
                refused  = (req.addr > IO_PORT_TOP);
                in_range = !refused;
                is_wr    = (req.op == out_op);
            end
            set_io_bit_op, clear_io_bit_op: begin
                refused  = (req.addr > BIT_OP_TOP);
                in_range = !refused;
                is_wr    = 1'b1;
                is_bit   = 1'b1;
            end
            skip_if_io_bit_one, skip_if_io_bit_zero: begin
                refused  = (req.addr > BIT_OP_TOP);
                in_range = !refused;
                is_skip  = 1'b1;
                want_one = (req.op == skip_if_io_bit_one);
            end
            load_indirect_op, load_direct_op, load_displaced_op,
            store_indirect_op, store_direct_op, store_displaced_op: begin
                // below the i/o window sits the core's own register file
                refused  = (req.addr < DATA_IO_BASE);
                in_range = !refused && (req.addr < EXT_IO_BASE);
                idx      = data_off[5:0];
                // extended space is accepted but holds nothing in this block
                is_wr    = (req.op == store_indirect_op) || (req.op == store_direct_op)
                           || (req.op == store_displaced_op);
            end
            default: refused = 1'b1;
        endcase
    end

    // ====================
    // read value and modify path
    always_comb begin
        cur = IO_RESET_VAL;
        if (in_range) begin
            case (kind_of(idx))
                kind_pin: cur = mem_q[idx];
                kind_rw:  cur = mem_q[idx] & mask_of(idx);
                kind_w1c: cur = mem_q[idx] & mask_of(idx);
                default:  cur = IO_RESET_VAL;
            endcase
        end
    end

    assign bit_m = BIT0_ONE << req.bit_sel;

    // whole-register rewrite: set flags in cur go back as ones and clear themselves, except the chosen bit of a bit clear
    always_comb begin
        wval = req.wdata;
        if (is_bit) begin
            if (req.op == set_io_bit_op) begin
                wval = cur | bit_m;
            end else begin
                wval = cur & ~bit_m;
            end
        end
    end

    assign wr_go = req_valid && in_range && is_wr;

    // ====================
    // register cells
    for (genvar gi = 0; gi < IO_COUNT; gi++) begin : g_reg
        localparam logic [5:0]  IDX = 6'(gi);
        localparam iorsd_kind_e K   = kind_of(IDX);
        localparam logic [7:0]  M   = mask_of(IDX);
        logic hit;
        assign hit = wr_go && (idx == IDX);
        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
                mem_q[gi] <= IO_RESET_VAL;
            end else begin
                case (K)
                    // pins are sampled each cycle; writes to them are dropped
                    kind_pin: mem_q[gi] <= port_pins[pin_sel(IDX)];
                    kind_rw: begin
                        if (hit) begin
                            mem_q[gi] <= (mem_q[gi] & ~M) | (wval & M);
                        end
                    end
                    kind_w1c: begin
                        // a new event in the clearing cycle survives
                        mem_q[gi] <= (mem_q[gi] & ~(hit ? (wval & M) : IO_RESET_VAL))
                                     | (flag_of(IDX, flag_set) & M);
                    end
                    default: mem_q[gi] <= IO_RESET_VAL;
                endcase
            end
        end
    end

    // ====================
    // answer register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rsp_q <= '0;
        end else begin
            rsp_q.valid   <= req_valid;
            rsp_q.refused <= req_valid && refused;
            rsp_q.skip    <= req_valid && is_skip && !refused
                             && (cur[req.bit_sel] == want_one);
            rsp_q.rdata   <= (req_valid && !is_wr && !refused) ? cur : IO_RESET_VAL;
        end
    end

    assign rsp      = rsp_q;
    assign io_image = mem_q;

endmodule

`default_nettype wire

// *** sim/iorsd_core_model.sv ***
// core-side model: issues one request per call and captures the registered answer
`timescale 1ns/1ps
`default_nettype none

module iorsd_core_model
    import iorsd_pkg::*;
(
    // clock
    input  wire logic                  core_clk,
    // request to the decoder
    output var  logic                  req_valid,
    output iorsd_pkg::iorsd_req_s      req,
    // answer from the decoder
    input  wire iorsd_pkg::iorsd_rsp_s rsp
);
    initial begin
        req_valid = 1'h0;
        req       = '0;
    end

    // ==================== request driver
    // request held until the taking edge; reserved targets only when a caller asks
    task automatic issue(input iorsd_op_e op, input logic [7:0] addr, input logic [2:0] bsel,
                         input logic [7:0] wd, output iorsd_rsp_s got);
        req_valid = 1'h1;
        req       = '{op, addr, bsel, wd};
        @(posedge core_clk);
        #1;
        got = rsp;
    endtask

    // released lines carry inverted data so a stale request never looks valid
    task automatic idle();
        req_valid = 1'h0;
        req       = iorsd_req_s'(~req);
    endtask
endmodule
`default_nettype wire

// *** sim/iorsd_top_sva.sv ***
// assertion checker for the i/o register space decoder, bound to its top
`timescale 1ns/1ps
`default_nettype none

module iorsd_chk
    import iorsd_pkg::*;
#(
    parameter int IO_W = 8
) (
    // clock and reset
    input wire logic                   core_clk,
    input wire logic                   nrst,
    // request and answer
    input wire logic                   req_valid,
    input wire iorsd_pkg::iorsd_req_s  req,
    input wire iorsd_pkg::iorsd_rsp_s  rsp,
    // peripheral side
    input wire logic [iorsd_pkg::NUM_PORTS-1:0][iorsd_pkg::DATA_W-1:0] port_pins,
    input wire iorsd_pkg::iorsd_flag_s flag_set,
    input wire logic [iorsd_pkg::IO_COUNT-1:0][iorsd_pkg::DATA_W-1:0]  io_image
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic bit_op, port_op, mem_op, load_op, skip_op;
    assign bit_op  = req.op inside {set_io_bit_op, clear_io_bit_op};
    assign port_op = req.op inside {in_op, out_op};
    assign mem_op  = req.op >= load_indirect_op && req.op <= store_displaced_op;
    assign load_op = req.op inside {load_indirect_op, load_direct_op, load_displaced_op};
    assign skip_op = req.op inside {skip_if_io_bit_one, skip_if_io_bit_zero};

    // ==================== answers
    AST_ANSWER_NEXT: assert property (rsp.valid == $past(req_valid))
        else $error("answer not exactly one cycle after request");
    AST_BIT_RANGE: assert property (req_valid && bit_op |=>
        rsp.refused == ($past(req.addr) > BIT_OP_TOP)) else $error("bit op range wrong");
    AST_SKIP_BIT: assert property (req_valid && skip_op && req.addr <= BIT_OP_TOP |=>
        !rsp.refused && rsp.rdata == $past(io_image[req.addr[5:0]]) && rsp.skip ==
        (rsp.rdata[$past(req.bit_sel)] ^ $past(req.op == skip_if_io_bit_zero)))
        else $error("skip test wrong");
    AST_SKIP_RANGE: assert property (req_valid && skip_op && req.addr > BIT_OP_TOP |=>
        rsp.refused && !rsp.skip) else $error("skip above bit range not refused");
    AST_PORT_RANGE: assert property (req_valid && port_op |=>
        rsp.refused == ($past(req.addr) > IO_PORT_TOP)) else $error("port op range wrong");
    AST_EXT_MEM: assert property (req_valid && mem_op && req.addr >= EXT_IO_BASE |=>
        !rsp.refused && rsp.rdata == 8'h00) else $error("extended access wrong");
    AST_DATA_OFS: assert property (req_valid && load_op &&
        req.addr inside {[8'h20:8'h5f]}
        |=> rsp.rdata == $past(io_image[6'(req.addr - DATA_IO_BASE)]))
        else $error("load offset wrong");
    AST_LOW_MEM: assert property (req_valid && mem_op && req.addr < DATA_IO_BASE |=>
        rsp.refused) else $error("low data access not refused");

    // ==================== flags and reserved places; flag_set held quiet in the flag checks so only the write acts
    AST_W1C_WRITE: assert property (req_valid && req.op == out_op && req.addr == 8'h15
        && flag_set.timer0 == 8'h00 |=> io_image[OFS_TIMER0_FLAGS] ==
        ($past(io_image[OFS_TIMER0_FLAGS]) & ~$past(req.wdata))) else $error("w1c wrong");
    AST_SET_FLUSH: assert property (req_valid && req.op == set_io_bit_op &&
        req.addr == 8'h15 && flag_set.timer0 == 8'h00 |=> io_image[OFS_TIMER0_FLAGS] == 8'h00)
        else $error("bit set left flags");
    AST_CLR_KEEP: assert property (req_valid && req.op == clear_io_bit_op &&
        req.addr == 8'h16 && flag_set.timer1 == 8'h00 |=> io_image[OFS_TIMER1_FLAGS] ==
        ($past(io_image[OFS_TIMER1_FLAGS]) & (8'h01 << $past(req.bit_sel))))
        else $error("bit clear write-back wrong");
    AST_RSVD_ZERO: assert property (io_image[6'h0c] == 8'h00 &&
        io_image[6'h3f] == 8'h00 &&
        (io_image[OFS_EXTERNAL_IRQ_MASK] & ~MSK_EXTERNAL_IRQ_MASK) == 8'h00)
        else $error("reserved place not zero");

    COV_SET: cover property (req_valid && req.op == set_io_bit_op && req.addr == 8'h15);
    COV_EXT: cover property (req_valid && mem_op && req.addr >= EXT_IO_BASE);
    COV_B2B: cover property (req_valid [*2]);
endmodule

bind iorsd_top iorsd_chk #(.IO_W(IO_W)) u_iorsd_chk (.core_clk(core_clk), .nrst(nrst),
    .req_valid(req_valid), .req(req), .rsp(rsp), .port_pins(port_pins),
    .flag_set(flag_set), .io_image(io_image));
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the i/o register space decoder
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import iorsd_pkg::*;

    typedef struct packed {
        iorsd_op_e  op;
        logic [7:0] addr;
        logic [2:0] bsel;
        logic [7:0] wd;
        logic       refd;
        logic       skp;
        logic [7:0] rd;
    } iorsd_row_s;

    logic                             core_clk;
    logic                             nrst;
    logic                             req_valid;
    iorsd_req_s                       req;
    iorsd_rsp_s                       rsp;
    logic [NUM_PORTS-1:0][DATA_W-1:0] port_pins;
    iorsd_flag_s                      flag_set;
    logic [IO_COUNT-1:0][DATA_W-1:0]  io_image;
    iorsd_rsp_s                       got;
    int                               err_count;
    int                               samples_checked;

    // rows run back to back, so each write is read in the very next cycle
    iorsd_row_s rows [31] = '{
        '{out_op, 8'h01, 3'h0, 8'ha5, 1'h0, 1'h0, 8'h00},
        '{in_op, 8'h01, 3'h0, 8'h00, 1'h0, 1'h0, 8'ha5},
        '{load_direct_op, 8'h21, 3'h0, 8'h00, 1'h0, 1'h0, 8'ha5},
        '{store_displaced_op, 8'h3e, 3'h0, 8'h3c, 1'h0, 1'h0, 8'h00},
        '{load_indirect_op, 8'h3e, 3'h0, 8'h00, 1'h0, 1'h0, 8'h3c},
        '{set_io_bit_op, 8'h1e, 3'h0, 8'h00, 1'h0, 1'h0, 8'h00},
        '{clear_io_bit_op, 8'h1e, 3'h2, 8'h00, 1'h0, 1'h0, 8'h00},
        '{load_displaced_op, 8'h3e, 3'h0, 8'h00, 1'h0, 1'h0, 8'h39},
        '{set_io_bit_op, 8'h20, 3'h0, 8'h00, 1'h1, 1'h0, 8'h00},
        '{skip_if_io_bit_one, 8'h1e, 3'h0, 8'h00, 1'h0, 1'h1, 8'h39},
        '{skip_if_io_bit_zero, 8'h1e, 3'h1, 8'h00, 1'h0, 1'h1, 8'h39},
        '{skip_if_io_bit_one, 8'h1e, 3'h1, 8'h00, 1'h0, 1'h0, 8'h39},
        '{skip_if_io_bit_zero, 8'h20, 3'h0, 8'h00, 1'h1, 1'h0, 8'h00},
        '{in_op, 8'h40, 3'h0, 8'h00, 1'h1, 1'h0, 8'h00},
        '{out_op, 8'h3f, 3'h0, 8'hff, 1'h0, 1'h0, 8'h00},
        '{in_op, 8'h3f, 3'h0, 8'h00, 1'h0, 1'h0, 8'h00},
        '{store_direct_op, 8'h60, 3'h0, 8'hff, 1'h0, 1'h0, 8'h00},
        '{load_direct_op, 8'hff, 3'h0, 8'h00, 1'h0, 1'h0, 8'h00},
        '{store_direct_op, 8'h1e, 3'h0, 8'hff, 1'h1, 1'h0, 8'h00},
        '{in_op, 8'h1e, 3'h0, 8'h00, 1'h0, 1'h0, 8'h39},
        '{out_op, 8'h1d, 3'h0, 8'hff, 1'h0, 1'h0, 8'h00},
        '{in_op, 8'h1d, 3'h0, 8'h00, 1'h0, 1'h0, 8'h07},
        '{out_op, 8'h00, 3'h0, 8'hff, 1'h0, 1'h0, 8'h00},
        '{in_op, 8'h00, 3'h0, 8'h00, 1'h0, 1'h0, 8'h96},
        '{in_op, 8'h03, 3'h0, 8'h00, 1'h0, 1'h0, 8'h0f},
        '{load_direct_op, 8'h26, 3'h0, 8'h00, 1'h0, 1'h0, 8'hc3},
        '{in_op, 8'h09, 3'h0, 8'h00, 1'h0, 1'h0, 8'h5a},
        '{store_indirect_op, 8'h2a, 3'h0, 8'h81, 1'h0, 1'h0, 8'h00},
        '{in_op, 8'h0a, 3'h0, 8'h00, 1'h0, 1'h0, 8'h81},
        '{iorsd_op_e'(4'hf), 8'h01, 3'h0, 8'hff, 1'h1, 1'h0, 8'h00},
        '{in_op, 8'h01, 3'h0, 8'h00, 1'h0, 1'h0, 8'ha5}};

    iorsd_top #(.IO_W(DATA_W)) dut (.core_clk(core_clk), .nrst(nrst), .req_valid(req_valid),
        .req(req), .rsp(rsp), .port_pins(port_pins), .flag_set(flag_set), .io_image(io_image));
    iorsd_core_model u_core (.core_clk(core_clk), .req_valid(req_valid), .req(req), .rsp(rsp));

    initial begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end

    // ==================== checking
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic do_op(input iorsd_row_s r);
        u_core.issue(r.op, r.addr, r.bsel, r.wd, got);
        check("valid", 8'(got.valid), 8'h01);
        check("refused", 8'(got.refused), 8'(r.refd));
        check("skip", 8'(got.skip), 8'(r.skp));
        check("rdata", got.rdata, r.rd);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog well beyond the roughly 51 cycles the run needs
    initial begin
        #20000;
        err_count++;
        give_verdict();
    end

    // ==================== sequence
    initial begin
        err_count = 0;
        samples_checked = 0;
        nrst = 1'h0;
        flag_set = '0;
        port_pins = {8'h5a, 8'hc3, 8'h0f, 8'h96};
        repeat (5) @(posedge core_clk);
        #1 nrst = 1'h1;
        foreach (rows[i]) begin
            do_op(rows[i]);
        end
        u_core.idle();
        flag_set = '1;
        @(posedge core_clk);
        #1 flag_set = '0;
        check("timer0 flags", io_image[OFS_TIMER0_FLAGS], 8'h07);
        check("timer1 flags", io_image[OFS_TIMER1_FLAGS], 8'h27);
        check("timer2 flags", io_image[OFS_TIMER2_FLAGS], 8'h07);
        check("pin change flags", io_image[OFS_PIN_CHANGE_FLAGS], 8'h0f);
        check("irq flags", io_image[OFS_EXTERNAL_IRQ_FLAGS], 8'h07);
        do_op('{out_op, 8'h15, 3'h0, 8'h01, 1'h0, 1'h0, 8'h00});
        do_op('{out_op, 8'h15, 3'h0, 8'h00, 1'h0, 1'h0, 8'h00});
        do_op('{in_op, 8'h15, 3'h0, 8'h00, 1'h0, 1'h0, 8'h06});
        do_op('{set_io_bit_op, 8'h15, 3'h2, 8'h00, 1'h0, 1'h0, 8'h00});
        do_op('{in_op, 8'h15, 3'h0, 8'h00, 1'h0, 1'h0, 8'h00});
        do_op('{clear_io_bit_op, 8'h16, 3'h5, 8'h00, 1'h0, 1'h0, 8'h00});
        do_op('{in_op, 8'h16, 3'h0, 8'h00, 1'h0, 1'h0, 8'h20});
        // a new event in the clearing cycle must survive the clear
        flag_set.timer0 = 8'h01;
        do_op('{out_op, 8'h15, 3'h0, 8'h01, 1'h0, 1'h0, 8'h00});
        flag_set = '0;
        check("set wins", io_image[OFS_TIMER0_FLAGS], 8'h01);
        // second reset in mid-run clears the cells and the answer
        u_core.idle();
        nrst = 1'h0;
        #1;
        check("reset cell", io_image[OFS_GENERAL_PURPOSE_0], 8'h00);
        check("reset answer", 8'(rsp.valid), 8'h00);
        repeat (5) @(posedge core_clk);
        #1 nrst = 1'h1;
        do_op('{in_op, 8'h1e, 3'h0, 8'h00, 1'h0, 1'h0, 8'h00});
        give_verdict();
    end
endmodule
`default_nettype wire
